// ===== verif/pmr_mgmt_master.sv
// Management entity model: sends preamble-led frames on mdc and mdio.
// Assumes mdio_wire is the resolved pin, pulled up when nobody drives.
`timescale 1ns/1ps
module pmr_mgmt_master (
  // Clock and pin
  input  wire logic mclk,
  input  wire logic mdio_wire,
  // Driven pins
  output logic      mdc,
  output logic      mdio_drive,
  output logic      mdio_en
);
  initial begin
    mdc        = 1'b0;
    mdio_drive = 1'b1;
    mdio_en    = 1'b0;
  end

  // Eight mclk per mdc half, well above the slave's sync margin
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      mdc        <= 1'b0;
      mdio_drive <= bits[63-i];
      mdio_en    <= !(op == 2'h2 && i >= 46);
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      if (i >= 48) rd[63-i] = mdio_wire;
      @(posedge mclk);
      mdc <= 1'b1;
      repeat (7) @(posedge mclk);
    end
    @(posedge mclk);
    mdc     <= 1'b0;
    mdio_en <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : frame
endmodule : pmr_mgmt_master

// ===== verif/pmr_register_set_sva.sv
// Checker for the register set: restart, duplex, advertisement outputs and mdio turnaround.
// Assumes one mclk domain and a management master with mdc halves of several mclk.
`timescale 1ns/1ps
module pmr_register_set_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Watched inputs
  input wire logic        negotiated_full_duplex,
  input wire logic        negotiation_started,
  input wire logic        partner_word_valid,
  // Watched outputs
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic        negotiation_enable,
  input wire logic        negotiation_restart,
  input wire logic        data_port_isolate,
  input wire logic        link_full_duplex,
  input wire logic [15:0] advertise_word,
  input wire logic        next_page_request,
  input wire logic        advertised_remote_fault,
  input wire logic [3:0]  transmit_level_adjust,
  input wire logic [1:0]  edge_rate_adjust
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_restart_req;
    $rose(negotiation_restart);
  endsequence
  // Turnaround low must last a good part of an mdc period, not a glitch
  sequence s_turn_low;
    (mdio_oe && !mdio_out) [*8];
  endsequence

  property p_restart_gated; s_restart_req |-> negotiation_enable; endproperty
  a_restart_gated: assert property (p_restart_gated) else $error("restart set while negotiation off");
  property p_restart_hold;
    negotiation_restart && !negotiation_started && negotiation_enable |=> negotiation_restart;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart dropped before start");
  property p_restart_clear; negotiation_restart && negotiation_started |=> !negotiation_restart; endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart kept after start");
  property p_duplex_auto; negotiation_enable |=> link_full_duplex == $past(negotiated_full_duplex); endproperty
  a_duplex_auto: assert property (p_duplex_auto) else $error("duplex not from negotiation");
  property p_turn; $rose(mdio_oe) |-> s_turn_low; endproperty
  a_turn: assert property (p_turn) else $error("turnaround not driven low");
  property p_oe_bounded; $rose(mdio_oe) |-> ##[1:300] $fell(mdio_oe); endproperty
  a_oe_bounded: assert property (p_oe_bounded) else $error("mdio drive too long");
  property p_next_page; next_page_request == advertise_word[15]; endproperty
  a_next_page: assert property (p_next_page) else $error("next page output mismatch");
  property p_adv_fault; advertised_remote_fault == advertise_word[13]; endproperty
  a_adv_fault: assert property (p_adv_fault) else $error("remote fault output mismatch");
  property p_adv_t4; (advertise_word & 16'h1e1e) == 16'h0000; endproperty
  a_adv_t4: assert property (p_adv_t4) else $error("unsupported mode advertised");
  property p_ack; partner_word_valid |-> ##2 advertise_word[14]; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not set");
  property p_reset_vals;
    $rose(reset_n) |-> advertise_word == 16'h01e1 && edge_rate_adjust == 2'h2
      && transmit_level_adjust == 4'h8 && negotiation_enable && data_port_isolate;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
endmodule : pmr_register_set_sva

// ===== verif/tb_top.sv
// Self-checking bench for the register set, reached through management frames and its core-side pins.
// Assumes the management model and the checker bound at the foot of this file.
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and pins
  logic        mclk, reset_n, mdc, mdio_in, mdio_out, mdio_oe, mdio_drive, mdio_en;
  // Core side
  logic        link_up, remote_fault_seen, jabber_seen, speed_is_100, negotiation_started;
  logic        negotiation_done, negotiated_full_duplex, partner_word_valid;
  logic [15:0] partner_word, advertise_word, rd_data;
  // Control and configuration outputs
  logic        negotiation_enable, negotiation_restart, data_port_isolate, link_full_duplex;
  logic        collision_test, next_page_request, advertised_remote_fault, link_detect_disable;
  logic        tp_transmit_disable, tp_transmit_powerdown, scrambler_bypass, unscrambled_idle_disable;
  logic        equalizer_disable, type_select_a, squelch_level_reduce;
  logic [3:0]  transmit_level_adjust;
  logic [1:0]  edge_rate_adjust;
  logic [13:0] cfg_outs;
  int          num_errors = 0;
  int          tests_run  = 0;

  // Pull-up wins when neither side drives
  assign mdio_in  = mdio_oe ? mdio_out : (mdio_en ? mdio_drive : 1'b1);
  assign cfg_outs = {link_detect_disable, tp_transmit_disable, tp_transmit_powerdown, scrambler_bypass,
                     unscrambled_idle_disable, equalizer_disable, type_select_a, squelch_level_reduce,
                     transmit_level_adjust, edge_rate_adjust};

  pmr_register_set pmr_register_set_i (.*);
  pmr_mgmt_master pmr_mgmt_master_i (.mclk(mclk), .mdio_wire(mdio_in), .mdc(mdc), .mdio_drive(mdio_drive),
                                     .mdio_en(mdio_en));

  always #5 mclk = ~mclk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    pmr_mgmt_master_i.frame(2'h1, 5'h00, ra, wd, rd_data);
  endtask : wr
  task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp,
                        input logic [4:0] phy = 5'h00);
    pmr_mgmt_master_i.frame(2'h2, phy, ra, 16'h0000, rd_data);
    chk(what, exp, rd_data);
  endtask : rd_chk
  // Core inputs land well before outputs are looked at
  task automatic settle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic test_reset_values();
    logic [4:0]  ra [7];
    logic [15:0] ex [7];
    ra = '{5'h01, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h10};
    ex = '{16'h7809, 16'h780d, pmr_pkg::IDENT_HIGH_VALUE, pmr_pkg::IDENT_LOW_VALUE, 16'h01e1, 16'h0000, 16'h0022};
    for (int i = 0; i < 7; i++) rd_chk("reset_read", ra[i], ex[i]);
    rd_chk("ctl_isolated", 5'h00, 16'h1400);
    rd_chk("unmapped", 5'h07, 16'h0000);
    rd_chk("wrong_phy", 5'h01, 16'hffff, 5'h01);
  endtask : test_reset_values

  task automatic test_config();
    logic [15:0] w;
    wr(5'h10, 16'hffff);
    rd_chk("cfg_mask", 5'h10, 16'he7ff);
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      wr(5'h10, w);
      chk("cfg_outs", {2'h0, w[15:13], w[10:0]}, {2'h0, cfg_outs});
    end
  endtask : test_config

  task automatic test_advertise();
    wr(5'h04, 16'hffff);
    rd_chk("adv_mask", 5'h04, 16'ha1e1);
    chk("adv_word", 16'ha1e1, advertise_word);
    chk("adv_bits", 16'h0003, {14'h0, next_page_request, advertised_remote_fault});
    wr(5'h05, 16'hffff);
    rd_chk("partner_ro", 5'h05, 16'h0000);
    wr(5'h04, 16'h01e1);
    chk("adv_bits_off", 16'h0000, {14'h0, next_page_request, advertised_remote_fault});
  endtask : test_advertise

  task automatic test_negotiation();
    negotiated_full_duplex <= 1'b1;
    wr(5'h00, 16'h1200);
    chk("ctl_outs", 16'h0006, {13'h0, negotiation_restart, negotiation_enable, data_port_isolate});
    wr(5'h00, 16'h1000);
    rd_chk("restart_held", 5'h00, 16'h1200);
    @(posedge mclk);
    negotiation_started <= 1'b1;
    @(posedge mclk);
    negotiation_started <= 1'b0;
    partner_word        <= 16'h45e1;
    partner_word_valid  <= 1'b1;
    negotiation_done    <= 1'b1;
    @(posedge mclk);
    partner_word_valid  <= 1'b0;
    negotiation_done    <= 1'b0;
    settle();
    chk_bit("restart_clear", 1'b0, negotiation_restart);
    chk_bit("ack", 1'b1, advertise_word[14]);
    chk_bit("manual_duplex_select_auto", 1'b1, link_full_duplex);
    rd_chk("partner", 5'h05, 16'h45e1);
    rd_chk("complete", 5'h01, 16'h782d);
    negotiated_full_duplex <= 1'b0;
    wr(5'h00, 16'h1100);
    chk_bit("manual_duplex_select_ignored", 1'b0, link_full_duplex);
    wr(5'h00, 16'h0100);
    chk_bit("manual_duplex_select_full", 1'b1, link_full_duplex);
    rd_chk("complete_off", 5'h01, 16'h780d);
    wr(5'h00, 16'h0200);
    chk("restart_off", 16'h0000, {14'h0, negotiation_restart, link_full_duplex});
    rd_chk("restart_reads0", 5'h00, 16'h0000);
    wr(5'h00, 16'h0080);
    chk_bit("coll_on", 1'b1, collision_test);
    wr(5'h00, 16'h0000);
    chk_bit("coll_off", 1'b0, collision_test);
  endtask : test_negotiation

  task automatic test_latches();
    @(posedge mclk);
    remote_fault_seen <= 1'b1;
    jabber_seen       <= 1'b1;
    link_up           <= 1'b0;
    @(posedge mclk);
    remote_fault_seen <= 1'b0;
    jabber_seen       <= 1'b0;
    link_up           <= 1'b1;
    settle();
    rd_chk("latched", 5'h01, 16'h781b);
    wr(5'h01, 16'h0000);
    rd_chk("cleared", 5'h01, 16'h780d);
    speed_is_100 <= 1'b1;
    jabber_seen  <= 1'b1;
    settle();
    @(posedge mclk);
    jabber_seen  <= 1'b0;
    rd_chk("jabber_fast", 5'h01, 16'h780d);
  endtask : test_latches

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    finish_test();
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    link_up = 1'b1;
    {remote_fault_seen, jabber_seen, speed_is_100, negotiation_started} = 4'h0;
    {negotiation_done, negotiated_full_duplex, partner_word_valid} = 3'h0;
    partner_word = 16'h0000;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    test_reset_values();
    test_config();
    test_advertise();
    test_negotiation();
    test_latches();
    finish_test();
  end
endmodule : tb_top

bind pmr_register_set pmr_register_set_sva pmr_register_set_sva_i (
  .mclk(mclk), .reset_n(reset_n), .negotiated_full_duplex(negotiated_full_duplex),
  .negotiation_started(negotiation_started), .partner_word_valid(partner_word_valid),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .negotiation_enable(negotiation_enable),
  .negotiation_restart(negotiation_restart), .data_port_isolate(data_port_isolate),
  .link_full_duplex(link_full_duplex), .advertise_word(advertise_word),
  .next_page_request(next_page_request), .advertised_remote_fault(advertised_remote_fault),
  .transmit_level_adjust(transmit_level_adjust), .edge_rate_adjust(edge_rate_adjust));

// ===== verilog/pmr_pkg.sv
// Constants for the PHY management register set: map, field positions, resets, frame timing.
// Assumes a single 100 MHz clock and a management master that keeps to the serial frame format.
package pmr_pkg;

  // Register addresses
  localparam logic [4:0] REG_CONTROL     = 5'h00;
  localparam logic [4:0] REG_STATUS      = 5'h01;
  localparam logic [4:0] REG_IDENT_HIGH  = 5'h02;
  localparam logic [4:0] REG_IDENT_LOW   = 5'h03;
  localparam logic [4:0] REG_ADVERTISE   = 5'h04;
  localparam logic [4:0] REG_PARTNER     = 5'h05;
  localparam logic [4:0] REG_CONFIG_ONE  = 5'h10;

  // Control register fields
  localparam int CTL_NEG_ENABLE = 12;
  localparam int CTL_ISOLATE    = 10;
  localparam int CTL_RESTART    = 9;
  localparam int CTL_DUPLEX     = 8;
  localparam int CTL_COLL_TEST  = 7;
  localparam logic CTL_NEG_ENABLE_RESET = 1'b1;
  localparam logic CTL_ISOLATE_RESET    = 1'b1;

  // Status register fields
  localparam logic [15:0] STATUS_FIXED = 16'h7809;
  localparam int ST_COMPLETE     = 5;
  localparam int ST_REMOTE_FAULT = 4;
  localparam int ST_LINK         = 2;
  localparam int ST_JABBER       = 1;

  // Identifier words, values arbitrary
  localparam logic [15:0] IDENT_HIGH_VALUE = 16'h0a5a;
  localparam logic [15:0] IDENT_LOW_VALUE  = 16'h5c31;

  // Advertisement fields
  localparam logic [15:0] ADV_RESET      = 16'h01e1;
  localparam logic [15:0] ADV_WRITE_MASK = 16'ha1e1;
  localparam int ADV_NEXT_PAGE    = 15;
  localparam int ADV_ACK          = 14;
  localparam int ADV_REMOTE_FAULT = 13;

  // Configuration one fields
  localparam logic [15:0] CFG_RESET      = 16'h0022;
  localparam logic [15:0] CFG_WRITE_MASK = 16'he7ff;
  localparam int CFG_LINK_DISABLE   = 15;
  localparam int CFG_TX_DISABLE     = 14;
  localparam int CFG_TX_POWERDOWN   = 13;
  localparam int CFG_SCR_BYPASS     = 10;
  localparam int CFG_UNSCR_DISABLE  = 9;
  localparam int CFG_EQ_DISABLE     = 8;
  localparam int CFG_TYPE_SELECT_A          = 7;
  localparam int CFG_SQUELCH        = 6;
  localparam int CFG_TLVL_LSB       = 2;
  localparam int CFG_EDGE_LSB       = 0;
  localparam logic [1:0] EDGE_MINUS_QUARTER = 2'h3;
  localparam logic [1:0] EDGE_NOMINAL       = 2'h2;
  localparam logic [1:0] EDGE_PLUS_QUARTER  = 2'h1;
  localparam logic [1:0] EDGE_PLUS_HALF     = 2'h0;

  // Management frame
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HEADER_LAST   = 6'h0b;
  localparam logic [5:0] DATA_LAST     = 6'h0f;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [4:0] MGMT_ADDRESS  = 5'h00;
  localparam logic [1:0] PIN_IDLE      = 2'h2;

  typedef enum logic [2:0] {
    PMR_PREAMBLE = 3'h0,
    PMR_START    = 3'h1,
    PMR_HEADER   = 3'h3,
    PMR_TURN     = 3'h2,
    PMR_DATA     = 3'h6
  } pmr_state_type;

endpackage : pmr_pkg

// ===== verilog/pmr_register_set.sv
// PHY management register set with its serial management slave.
// Assumes core status inputs are on mclk; mdc and mdio come from outside and are resynchronised.
`timescale 1ns/1ps
module pmr_register_set (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Management serial pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Core status
  input  wire logic        link_up,
  input  wire logic        remote_fault_seen,
  input  wire logic        jabber_seen,
  input  wire logic        speed_is_100,
  input  wire logic        negotiation_started,
  input  wire logic        negotiation_done,
  input  wire logic        negotiated_full_duplex,
  input  wire logic        partner_word_valid,
  input  wire logic [15:0] partner_word,
  // Control outputs
  output logic             negotiation_enable,
  output logic             negotiation_restart,
  output logic             data_port_isolate,
  output logic             link_full_duplex,
  output logic             collision_test,
  output logic [15:0]      advertise_word,
  output logic             next_page_request,
  output logic             advertised_remote_fault,
  // Configuration outputs
  output logic             link_detect_disable,
  output logic             tp_transmit_disable,
  output logic             tp_transmit_powerdown,
  output logic             scrambler_bypass,
  output logic             unscrambled_idle_disable,
  output logic             equalizer_disable,
  output logic             type_select_a,
  output logic             squelch_level_reduce,
  output logic [3:0]       transmit_level_adjust,
  output logic [1:0]       edge_rate_adjust
);

  logic [1:0]              pin_raw;
  logic [2:0]              pin_sync [0:1];
  logic [1:0]              pin_level;
  logic                    mdc_prev;
  logic                    mdc_rise;
  logic                    mdio_bit;

  pmr_pkg::pmr_state_type  state;
  logic [5:0]              bit_count;
  logic [15:0]             shift_in;
  logic [15:0]             shift_out;
  logic                    is_read;
  logic [4:0]              frame_reg;
  logic [11:0]             header;

  logic                    write_strobe;
  logic [4:0]              write_addr;
  logic [15:0]             write_data;
  logic                    status_read;

  logic                    manual_duplex_select;
  logic                    complete_flag;
  logic                    remote_fault_status;
  logic                    link_latched;
  logic                    jabber_status;
  logic [15:0]             partner_abilities;
  logic [15:0]             negotiation_advertise;
  logic [15:0]             phy_config_one;
  logic                    ack_flag;
  logic                    restart_request;
  logic                    negotiation_complete;

  assign pin_raw   = {mdio_in, mdc};
  assign mdc_rise  = pin_level[0] & ~mdc_prev;
  assign mdio_bit  = pin_level[1];
  assign header    = {shift_in[10:0], mdio_bit};
  assign restart_request = write_strobe && (write_addr == pmr_pkg::REG_CONTROL) &&
                           write_data[pmr_pkg::CTL_RESTART] && write_data[pmr_pkg::CTL_NEG_ENABLE];
  assign negotiation_complete = complete_flag & negotiation_enable;

  // Three stages; a level counts only once the last two agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          pin_sync[g]  <= {3{pmr_pkg::PIN_IDLE[g]}};
          pin_level[g] <= pmr_pkg::PIN_IDLE[g];
        end else begin
          pin_sync[g] <= {pin_sync[g][1:0], pin_raw[g]};
          if (pin_sync[g][2] == pin_sync[g][1]) begin
            pin_level[g] <= pin_sync[g][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= pin_level[0];
    end
  end

  function automatic logic [15:0] read_word(input logic [4:0] addr);
    logic [15:0] w;
    w = '0;
    if (addr == pmr_pkg::REG_CONTROL) begin
      w[pmr_pkg::CTL_NEG_ENABLE] = negotiation_enable;
      w[pmr_pkg::CTL_ISOLATE]    = data_port_isolate;
      w[pmr_pkg::CTL_RESTART]    = negotiation_restart & negotiation_enable;
      w[pmr_pkg::CTL_DUPLEX]     = manual_duplex_select;
      w[pmr_pkg::CTL_COLL_TEST]  = collision_test;
    end else if (addr == pmr_pkg::REG_STATUS) begin
      w = pmr_pkg::STATUS_FIXED;
      w[pmr_pkg::ST_COMPLETE]     = negotiation_complete;
      w[pmr_pkg::ST_REMOTE_FAULT] = remote_fault_status;
      w[pmr_pkg::ST_LINK]         = link_latched;
      w[pmr_pkg::ST_JABBER]       = jabber_status & ~speed_is_100;
    end else if (addr == pmr_pkg::REG_IDENT_HIGH) begin
      w = pmr_pkg::IDENT_HIGH_VALUE;
    end else if (addr == pmr_pkg::REG_IDENT_LOW) begin
      w = pmr_pkg::IDENT_LOW_VALUE;
    end else if (addr == pmr_pkg::REG_ADVERTISE) begin
      w = negotiation_advertise;
    end else if (addr == pmr_pkg::REG_PARTNER) begin
      w = partner_abilities;
    end else if (addr == pmr_pkg::REG_CONFIG_ONE) begin
      w = phy_config_one;
    end
    return w;
  endfunction : read_word

  // Serial frame engine; isolation never stops it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= pmr_pkg::PMR_PREAMBLE;
      bit_count    <= '0;
      shift_in     <= '0;
      shift_out    <= '0;
      is_read      <= 1'b0;
      frame_reg    <= '0;
      write_strobe <= 1'b0;
      write_addr   <= '0;
      write_data   <= '0;
      status_read  <= 1'b0;
      mdio_out     <= 1'b0;
      mdio_oe      <= 1'b0;
    end else begin
      write_strobe <= 1'b0;
      status_read  <= 1'b0;
      if (mdc_rise) begin
        case (state)
          pmr_pkg::PMR_PREAMBLE: begin
            if (mdio_bit) begin
              if (bit_count != pmr_pkg::PREAMBLE_BITS) begin
                bit_count <= bit_count + 6'h01;
              end
            end else begin
              if (bit_count == pmr_pkg::PREAMBLE_BITS) begin
                state <= pmr_pkg::PMR_START;
              end
              bit_count <= '0;
            end
          end
          pmr_pkg::PMR_START: begin
            bit_count <= '0;
            state     <= mdio_bit ? pmr_pkg::PMR_HEADER : pmr_pkg::PMR_PREAMBLE;
          end
          pmr_pkg::PMR_HEADER: begin
            shift_in  <= {shift_in[14:0], mdio_bit};
            bit_count <= bit_count + 6'h01;
            if (bit_count == pmr_pkg::HEADER_LAST) begin
              bit_count <= '0;
              is_read   <= (header[11:10] == pmr_pkg::OP_READ);
              frame_reg <= header[4:0];
              // Frames for another address or bad opcodes are dropped quietly
              if ((header[9:5] == pmr_pkg::MGMT_ADDRESS) &&
                  ((header[11:10] == pmr_pkg::OP_READ) || (header[11:10] == pmr_pkg::OP_WRITE))) begin
                state <= pmr_pkg::PMR_TURN;
                if (header[11:10] == pmr_pkg::OP_READ) begin
                  shift_out   <= read_word(header[4:0]);
                  status_read <= (header[4:0] == pmr_pkg::REG_STATUS);
                end
              end else begin
                state <= pmr_pkg::PMR_PREAMBLE;
              end
            end
          end
          pmr_pkg::PMR_TURN: begin
            if (bit_count == '0) begin
              bit_count <= 6'h01;
              mdio_out  <= 1'b0;
              mdio_oe   <= is_read;
            end else begin
              bit_count <= '0;
              state     <= pmr_pkg::PMR_DATA;
              mdio_out  <= shift_out[15];
              shift_out <= {shift_out[14:0], 1'b0};
            end
          end
          pmr_pkg::PMR_DATA: begin
            shift_in  <= {shift_in[14:0], mdio_bit};
            bit_count <= bit_count + 6'h01;
            mdio_out  <= shift_out[15];
            shift_out <= {shift_out[14:0], 1'b0};
            if (bit_count == pmr_pkg::DATA_LAST) begin
              bit_count    <= '0;
              state        <= pmr_pkg::PMR_PREAMBLE;
              mdio_oe      <= 1'b0;
              mdio_out     <= 1'b0;
              write_strobe <= ~is_read;
              write_addr   <= frame_reg;
              write_data   <= {shift_in[14:0], mdio_bit};
            end
          end
          default: begin
            state     <= pmr_pkg::PMR_PREAMBLE;
            bit_count <= '0;
          end
        endcase
      end
    end
  end

  // Control register; unlisted bits are not stored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      negotiation_enable   <= pmr_pkg::CTL_NEG_ENABLE_RESET;
      data_port_isolate    <= pmr_pkg::CTL_ISOLATE_RESET;
      manual_duplex_select <= 1'b0;
      collision_test       <= 1'b0;
    end else if (write_strobe && (write_addr == pmr_pkg::REG_CONTROL)) begin
      negotiation_enable   <= write_data[pmr_pkg::CTL_NEG_ENABLE];
      data_port_isolate    <= write_data[pmr_pkg::CTL_ISOLATE];
      manual_duplex_select <= write_data[pmr_pkg::CTL_DUPLEX];
      collision_test       <= write_data[pmr_pkg::CTL_COLL_TEST];
    end
  end

  // Restart stays up until the core reports negotiation started or negotiation_enable is cleared
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      negotiation_restart <= 1'b0;
    end else if (restart_request) begin
      negotiation_restart <= 1'b1;
    end else if (negotiation_started || !negotiation_enable) begin
      negotiation_restart <= 1'b0;
    end
  end

  // Duplex decision
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_full_duplex <= 1'b0;
    end else if (negotiation_enable) begin
      link_full_duplex <= negotiated_full_duplex;
    end else begin
      link_full_duplex <= manual_duplex_select;
    end
  end

  // Completion flag; done wins over a restart in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      complete_flag <= 1'b0;
    end else if (negotiation_done && negotiation_enable) begin
      complete_flag <= 1'b1;
    end else if (restart_request || !negotiation_enable) begin
      complete_flag <= 1'b0;
    end
  end

  // Latched status; a new event beats the read that clears it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      remote_fault_status <= 1'b0;
      jabber_status       <= 1'b0;
      link_latched        <= 1'b0;
    end else begin
      if (remote_fault_seen) begin
        remote_fault_status <= 1'b1;
      end else if (status_read) begin
        remote_fault_status <= 1'b0;
      end
      if (jabber_seen && !speed_is_100) begin
        jabber_status <= 1'b1;
      end else if (status_read) begin
        jabber_status <= 1'b0;
      end
      if (status_read) begin
        link_latched <= link_up;
      end else begin
        link_latched <= link_latched & link_up;
      end
    end
  end

  // Partner abilities and acknowledge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      partner_abilities <= '0;
      ack_flag          <= 1'b0;
    end else if (partner_word_valid) begin
      partner_abilities <= partner_word;
      ack_flag          <= 1'b1;
    end else if (restart_request) begin
      ack_flag <= 1'b0;
    end
  end

  // Advertisement; unsupported and reserved bits cannot be set
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      negotiation_advertise <= pmr_pkg::ADV_RESET;
    end else begin
      if (write_strobe && (write_addr == pmr_pkg::REG_ADVERTISE)) begin
        negotiation_advertise <= write_data & pmr_pkg::ADV_WRITE_MASK;
      end else begin
        negotiation_advertise <= negotiation_advertise & pmr_pkg::ADV_WRITE_MASK;
      end
      negotiation_advertise[pmr_pkg::ADV_ACK] <= ack_flag;
    end
  end

  assign advertise_word          = negotiation_advertise;
  assign next_page_request       = negotiation_advertise[pmr_pkg::ADV_NEXT_PAGE];
  assign advertised_remote_fault = negotiation_advertise[pmr_pkg::ADV_REMOTE_FAULT];

  // Configuration one; reserved bits held at zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phy_config_one <= pmr_pkg::CFG_RESET;
    end else if (write_strobe && (write_addr == pmr_pkg::REG_CONFIG_ONE)) begin
      phy_config_one <= write_data & pmr_pkg::CFG_WRITE_MASK;
    end
  end

  assign link_detect_disable      = phy_config_one[pmr_pkg::CFG_LINK_DISABLE];
  assign tp_transmit_disable      = phy_config_one[pmr_pkg::CFG_TX_DISABLE];
  assign tp_transmit_powerdown    = phy_config_one[pmr_pkg::CFG_TX_POWERDOWN];
  assign scrambler_bypass         = phy_config_one[pmr_pkg::CFG_SCR_BYPASS];
  assign unscrambled_idle_disable = phy_config_one[pmr_pkg::CFG_UNSCR_DISABLE];
  assign equalizer_disable        = phy_config_one[pmr_pkg::CFG_EQ_DISABLE];
  assign type_select_a            = phy_config_one[pmr_pkg::CFG_TYPE_SELECT_A];
  assign squelch_level_reduce     = phy_config_one[pmr_pkg::CFG_SQUELCH];
  assign transmit_level_adjust    = phy_config_one[pmr_pkg::CFG_TLVL_LSB +: 4];
  assign edge_rate_adjust         = phy_config_one[pmr_pkg::CFG_EDGE_LSB +: 2];

endmodule : pmr_register_set
